/* File: dstu_top.sv */
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "dstu_defines.svh"
// Overview of operation
// - descriptor holds start address, word count and presence flag.
// - present descriptor: address is memory location, accessed directly.
// - absent descriptor raises segment-absent interrupt, no memory access.
// - software rewrites descriptor with presence set and new address.
// - index equal to word count raises a limit interrupt.
// - stack pointer is address wide, holds last referenced stack slot.
// - a push that spills increments, a pop that refills from memory decrements the stack pointer.
// - all stack traffic passes through two top-of-stack registers.
// - save pushes state to stack; restore pops it back.
// - each memory word carries a 3-bit tag.
// - code-tagged words refuse store; push spills and save write unchecked; data words stay writable.
// - operators take operands from the top-of-stack registers only.
// - fetch address formed from lexical level and index couple.
// - operators combine the two most recent operands, result on stack.
module dstu_top (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // interrupt
  output      logic        irq
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {S_IDLE, S_RD, S_RDW, S_WR, S_FIN} state_t;
  state_t state;
  dstu_pkg::cmd_t cmd, go_cmd;
  dstu_pkg::desc_t desc;
  dstu_pkg::couple_t couple;
  logic [15:0] sp, index, dbase, result, pend_addr;
  dstu_pkg::tword_t tos_a, tos_b, mem_w, mem_r, spill;
  logic        tos_full_a, tos_full_b;
  logic [`ST_NBITS-1:0] status, mask, ev;
  logic [2:0]  wtag, go_tag;
  logic        mem_we, is_code, is_desc, refuse, save_phase;
  logic [`MEM_AW-1:0] mem_a;
  logic        apb_wr, apb_rd, go, busy;
  logic [15:0] next_sp;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign busy   = (state != S_IDLE);
  assign go     = apb_wr && paddr == `OFF_CTRL && pwdata[`CTRL_GO_BIT] && !busy;
  // command and tag taken from the go write itself; cmd and wtag land at that same edge, as on any ctrl write while idle
  assign go_cmd = dstu_pkg::cmd_t'(pwdata[`CTRL_CMD_MSB:`CTRL_CMD_LSB]);
  assign go_tag = pwdata[`CTRL_TAG_MSB:`CTRL_TAG_LSB];

  tag_check u_chk (
    .tag     (mem_w.tag),
    .write   (mem_we),
    .is_code (),
    .is_desc (),
    .refuse  ()
  );
  // read side check on word about to be overwritten
  tag_check u_old (
    .tag     (mem_r.tag),
    .write   (state == S_RDW),
    .is_code (is_code),
    .is_desc (is_desc),
    .refuse  (refuse)
  );

  tag_mem u_mem (
    .pclk  (pclk),
    .we    (mem_we),
    .addr  (mem_a),
    .wdata (mem_w),
    .rdata (mem_r)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb write of plain registers; descriptor rewrite by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desc   <= '0;
      mask   <= `MASK_RESET;
      index  <= 16'h0000;
      couple <= '0;
      dbase  <= 16'h0000;
      cmd    <= dstu_pkg::CMD_PUSH;
      wtag   <= `TAG_DATA;
    end else begin
      if (apb_wr && !busy) begin
        if (paddr == `OFF_MASK) begin
          mask <= pwdata[`ST_NBITS-1:0];
        end else if (paddr == `OFF_DESC_LO) begin
          desc.addr  <= pwdata[15:0];
          desc.count <= pwdata[31:16];
        end else if (paddr == `OFF_DESC_HI) begin
          desc.present <= pwdata[`DESC_PRES_BIT];
        end else if (paddr == `OFF_INDEX) begin
          index <= pwdata[15:0];
        end else if (paddr == `OFF_COUPLE) begin
          couple <= pwdata[15:0];
        end else if (paddr == `OFF_DBASE) begin
          dbase <= pwdata[15:0];
        end else if (paddr == `OFF_CTRL) begin
          cmd  <= dstu_pkg::cmd_t'(pwdata[`CTRL_CMD_MSB:`CTRL_CMD_LSB]);
          wtag <= pwdata[`CTRL_TAG_MSB:`CTRL_TAG_LSB];
        end
      end else if (state == S_FIN && cmd == dstu_pkg::CMD_STEP && index != desc.count) begin
        index <= index + 16'h0001;  // segment indexing walks toward the count
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb read mux; status read clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `OFF_CTRL) begin
        prdata <= {21'h000000, wtag, cmd, 3'h0, busy};
      end else if (paddr == `OFF_STATUS) begin
        prdata <= {27'h0000000, status};
      end else if (paddr == `OFF_MASK) begin
        prdata <= {27'h0000000, mask};
      end else if (paddr == `OFF_SP) begin
        prdata <= {16'h0000, sp};
      end else if (paddr == `OFF_TOS_A) begin
        prdata <= tos_a.value;
      end else if (paddr == `OFF_TOS_B) begin
        prdata <= tos_b.value;
      end else if (paddr == `OFF_DESC_LO) begin
        prdata <= {desc.count, desc.addr};
      end else if (paddr == `OFF_DESC_HI) begin
        prdata <= {31'h00000000, desc.present};
      end else if (paddr == `OFF_INDEX) begin
        prdata <= {16'h0000, index};
      end else if (paddr == `OFF_COUPLE) begin
        prdata <= {16'h0000, couple};
      end else if (paddr == `OFF_RESULT) begin
        prdata <= {16'h0000, result};
      end else if (paddr == `OFF_DBASE) begin
        prdata <= {16'h0000, dbase};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // unmapped addresses answer with an error
  assign pslverr = psel && penable && (paddr > `OFF_DBASE || paddr[1:0] != 2'h0);

  ////////////////////////////////////////////////////////////////////////
  // sticky status; set wins over the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else if (apb_rd && paddr == `OFF_STATUS) begin
      status <= (status & ~prdata[`ST_NBITS-1:0]) | ev;  // clear only what the setup cycle reported
    end else begin
      status <= status | ev;
    end
  end
  assign irq = |(status & mask);

  ////////////////////////////////////////////////////////////////////////
  // operation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= S_IDLE;
      sp         <= `SP_RESET;
      tos_a      <= '0;
      tos_b      <= '0;
      tos_full_a <= 1'b0;
      tos_full_b <= 1'b0;
      result     <= 16'h0000;
      pend_addr  <= 16'h0000;
      save_phase <= 1'b0;
      spill      <= '0;
      ev         <= '0;
    end else begin
      ev <= '0;
      case (state)
        S_IDLE: begin
          if (go) begin
            state <= S_FIN;
            case (go_cmd)
              dstu_pkg::CMD_PUSH: begin
                // new value enters the top pair; a full b spills to memory
                tos_b <= tos_a;
                tos_a <= '{tag: go_tag, value: {16'h0000, desc.addr}};
                tos_full_a <= 1'b1;
                tos_full_b <= tos_full_a;
                if (tos_full_b) begin
                  spill <= tos_b;                      // displaced word, b is overwritten now
                  sp <= sp + 16'h0001;
                  pend_addr <= sp + 16'h0001;
                  state <= S_WR;
                end
              end
              dstu_pkg::CMD_POP: begin
                if (!tos_full_a) begin
                  ev[`ST_UNDER] <= 1'b1;
                end else begin
                  tos_a <= tos_b;
                  tos_full_a <= tos_full_b;
                  tos_full_b <= 1'b0;
                  if (tos_full_b && sp != `SP_RESET) begin  // memory part empty at reset value
                    pend_addr <= sp;
                    state <= S_RD;
                  end
                end
              end
              dstu_pkg::CMD_ADD, dstu_pkg::CMD_SUB, dstu_pkg::CMD_MUL: begin
                // zero-address operator on the two newest operands
                if (!(tos_full_a && tos_full_b)) begin
                  ev[`ST_UNDER] <= 1'b1;
                end else begin
                  if (go_cmd == dstu_pkg::CMD_ADD) begin
                    tos_a.value <= tos_b.value + tos_a.value;
                  end else if (go_cmd == dstu_pkg::CMD_SUB) begin
                    tos_a.value <= tos_b.value - tos_a.value;
                  end else begin
                    tos_a.value <= 32'(tos_b.value * tos_a.value);
                  end
                  tos_a.tag <= `TAG_DATA;
                  tos_full_b <= 1'b0;
                  if (sp != `SP_RESET) begin
                    pend_addr <= sp;
                    state <= S_RD;
                  end
                end
              end
              dstu_pkg::CMD_FETCH, dstu_pkg::CMD_STORE: begin
                // address couple: level base offset plus index
                pend_addr <= dbase + {8'h00, couple.level, 4'h0} + {4'h0, couple.index};
                state <= S_RD;  // registered read: old word needs a cycle before its tag is judged
              end
              dstu_pkg::CMD_REF: begin
                if (!desc.present) begin
                  ev[`ST_ABSENT] <= 1'b1;
                end else begin
                  pend_addr <= desc.addr + index;
                  state <= S_RD;
                end
              end
              dstu_pkg::CMD_STEP: begin
                if (index == desc.count || index + 16'h0001 == desc.count) begin
                  ev[`ST_LIMIT] <= 1'b1;
                end
              end
              dstu_pkg::CMD_SAVE: begin
                // both top registers go to the stack
                save_phase <= 1'b1;
                pend_addr <= sp + 16'h0001;
                sp <= sp + 16'h0002;
                state <= S_WR;
              end
              dstu_pkg::CMD_RESTORE: begin
                pend_addr <= sp;
                save_phase <= 1'b1;
                state <= S_RD;
              end
              default: state <= S_FIN;
            endcase
          end
        end
        S_RD: begin
          state <= S_RDW;
        end
        S_RDW: begin
          state <= S_FIN;
          if (cmd == dstu_pkg::CMD_STORE) begin
            if (refuse) begin
              ev[`ST_PROTECT] <= 1'b1;
            end else begin
              state <= S_WR;
            end
          end else if (cmd == dstu_pkg::CMD_REF || cmd == dstu_pkg::CMD_FETCH) begin
            result <= mem_r.value[15:0];
            tos_b <= tos_a;
            tos_a <= mem_r;
            tos_full_a <= 1'b1;
            tos_full_b <= tos_full_a;
          end else begin
            // refill b from memory after pop or operator
            tos_b <= mem_r;
            tos_full_b <= 1'b1;
            if (cmd == dstu_pkg::CMD_RESTORE && save_phase) begin
              // top slot holds the saved b; a follows from the slot below
              save_phase <= 1'b0;
              pend_addr <= sp - 16'h0001;
              state <= S_RD;
            end else if (cmd == dstu_pkg::CMD_RESTORE) begin
              tos_a <= mem_r;
              tos_b <= tos_b;                          // keep the word restored first
              tos_full_a <= 1'b1;
              sp <= next_sp;
            end else begin
              sp <= next_sp;
            end
          end
        end
        S_WR: begin
          if (cmd == dstu_pkg::CMD_SAVE && save_phase) begin
            save_phase <= 1'b0;
            pend_addr <= pend_addr + 16'h0001;
          end else begin
            state <= S_FIN;
          end
        end
        S_FIN: begin
          ev[`ST_DONE] <= 1'b1;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    next_sp = (cmd == dstu_pkg::CMD_RESTORE) ? sp - 16'h0002 : sp - 16'h0001;
  end

  // memory port; store word keeps the tag tos_a was pushed with
  assign mem_a  = pend_addr[`MEM_AW-1:0];
  assign mem_we = (state == S_WR);
  always_comb begin
    if (cmd == dstu_pkg::CMD_STORE) begin
      mem_w = tos_a;
    end else if (cmd == dstu_pkg::CMD_SAVE) begin
      mem_w = save_phase ? tos_a : tos_b;
    end else begin
      mem_w = spill;  // push writes the word it displaced
    end
  end

  ////////////////////////////////////////////////////////////////////////
  chk_absent_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_IDLE && go && go_cmd == dstu_pkg::CMD_REF && !desc.present) |=> ev[`ST_ABSENT] && state == S_FIN)
    else $error("absent descriptor did not fault");
  chk_no_code_write: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_RDW && cmd == dstu_pkg::CMD_STORE && refuse) |=> !mem_we && ev[`ST_PROTECT])
    else $error("code word written");
  chk_push_sp: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_IDLE && go && go_cmd == dstu_pkg::CMD_PUSH && tos_full_b) |=> sp == $past(sp) + 16'h0001)
    else $error("push did not advance sp");
  chk_limit_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_IDLE && go && go_cmd == dstu_pkg::CMD_STEP && index + 16'h0001 == desc.count) |=> ev[`ST_LIMIT])
    else $error("limit missed");
  chk_event_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (|ev) |=> ((status & $past(ev)) == $past(ev)))
    else $error("event lost from status");
  chk_add_result: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_IDLE && go && go_cmd == dstu_pkg::CMD_ADD && tos_full_a && tos_full_b)
    |=> tos_a.value == $past(tos_a.value) + $past(tos_b.value))
    else $error("add wrong");
  chk_op_done: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_IDLE && go) |=> ##[0:5] state == S_FIN)
    else $error("operation hung");
  chk_present_ref: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_IDLE && go && go_cmd == dstu_pkg::CMD_REF && desc.present)
    |=> state == S_RD && pend_addr == $past(desc.addr + index))
    else $error("present ref address wrong");
  cov_absent: cover property (@(posedge pclk) ev[`ST_ABSENT]);
  cov_protect: cover property (@(posedge pclk) ev[`ST_PROTECT]);
  cov_spill: cover property (@(posedge pclk) state == S_WR && cmd == dstu_pkg::CMD_PUSH);
endmodule

/* File: dstu_defines.svh */
`ifndef DSTU_DEFINES_SVH
`define DSTU_DEFINES_SVH
// register byte offsets
`define OFF_CTRL      12'h000
`define OFF_STATUS    12'h004
`define OFF_MASK      12'h008
`define OFF_SP        12'h00C
`define OFF_TOS_A     12'h010
`define OFF_TOS_B     12'h014
`define OFF_DESC_LO   12'h018
`define OFF_DESC_HI   12'h01C
`define OFF_INDEX     12'h020
`define OFF_COUPLE    12'h024
`define OFF_RESULT    12'h028
`define OFF_DBASE     12'h02C
// control register fields
`define CTRL_GO_BIT   0
`define CTRL_CMD_LSB  4
`define CTRL_CMD_MSB  7
`define CTRL_TAG_LSB  8
`define CTRL_TAG_MSB  10
// status bit positions
`define ST_ABSENT     0
`define ST_LIMIT      1
`define ST_PROTECT    2
`define ST_DONE       3
`define ST_UNDER      4
`define ST_NBITS      5
// tag encodings
`define TAG_DATA      3'h0
`define TAG_DESC      3'h5
`define TAG_CODE      3'h3
// reset values
`define SP_RESET      16'h0100
`define MASK_RESET    5'h00
// descriptor layout: addr[15:0], count[31:16], presence in hi[0]
`define DESC_PRES_BIT 0
`define MEM_AW        8
`endif

/* File: dstu_pkg.sv */
package dstu_pkg;
  typedef enum logic [3:0] {
    CMD_PUSH, CMD_POP, CMD_ADD, CMD_SUB, CMD_MUL,
    CMD_FETCH, CMD_STORE, CMD_REF, CMD_STEP, CMD_SAVE, CMD_RESTORE
  } cmd_t;
  typedef struct packed {
    logic        present;
    logic [15:0] count;
    logic [15:0] addr;
  } desc_t;
  typedef struct packed {
    logic [2:0]  tag;
    logic [31:0] value;
  } tword_t;
  typedef struct packed {
    logic [3:0]  level;
    logic [11:0] index;
  } couple_t;
endpackage

/* File: tag_mem.sv */
`timescale 1ns/1ps
`include "dstu_defines.svh"
module tag_mem (
  // clock
  input  wire logic                   pclk,
  // access
  input  wire logic                   we,
  input  wire logic [`MEM_AW-1:0]     addr,
  input  wire dstu_pkg::tword_t       wdata,
  output      dstu_pkg::tword_t       rdata
);
  dstu_pkg::tword_t mem [0:(1<<`MEM_AW)-1];

  // registered read, write-first not needed by caller
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

/* File: tag_check.sv */
`timescale 1ns/1ps
`include "dstu_defines.svh"
module tag_check (
  // word under test
  input  wire logic [2:0] tag,
  input  wire logic       write,
  // decode
  output      logic       is_code,
  output      logic       is_desc,
  output      logic       refuse
);
  // one decode for every tag check keeps encodings consistent
  assign is_code = (tag == `TAG_CODE);
  assign is_desc = (tag == `TAG_DESC);
  assign refuse  = write && is_code;
endmodule

/* File: dstu_top_tb_top.sv */
`timescale 1ns/1ps
`include "dstu_defines.svh"
module dstu_top_tb_top;
  typedef struct {
    logic [31:0] val;
    logic [31:0] msk;
    logic        err;
  } exp_t;
  localparam logic [31:0] m16  = 32'h0000FFFF;
  localparam logic [31:0] mall = 32'hFFFFFFFF;
  localparam logic [31:0] s_ab = 32'h1 << `ST_ABSENT;
  localparam logic [31:0] s_lm = 32'h1 << `ST_LIMIT;
  localparam logic [31:0] s_pr = 32'h1 << `ST_PROTECT;
  localparam logic [31:0] s_dn = 32'h1 << `ST_DONE;
  localparam logic [31:0] s_un = 32'h1 << `ST_UNDER;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  int          bad_count;
  int          checks;
  int          cycles;
  exp_t        exp_q[$];
  exp_t        e;
  logic [31:0] rd;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] r;
  logic [31:0] sp;
  dstu_pkg::cmd_t ops[3] = '{dstu_pkg::CMD_ADD, dstu_pkg::CMD_SUB, dstu_pkg::CMD_MUL};

  dstu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                .irq(irq));

  ////////////////////////////////////////////////////////////
  // free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // every completed read takes the oldest note; a zero mask with no error expected leaves the read unchecked
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e = exp_q.pop_front();
      if (e.msk != 0 || e.err) begin
        checks++;
        if (((prdata & e.msk) !== (e.val & e.msk)) || (pslverr !== e.err)) begin
          bad_count++;
          $display("[ERR] t=%0t got %h/%h exp %h/%h", $time, prdata, pslverr, e.val, e.err);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // one apb transfer; an idle edge first so psel never drops and rises together
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask

  task automatic rd_chk(input logic [11:0] ad, input logic [31:0] v, input logic [31:0] m, input logic er);
    exp_q.push_back('{v, m, er});
    apb(1'b0, ad, 32'h00000000);
  endtask

  // start a command and poll busy, bounded
  task automatic run(input dstu_pkg::cmd_t c, input logic [2:0] tg);
    int n = 0;
    wr(`OFF_CTRL, {21'h000000, tg, c, 3'h0, 1'b1});
    do begin
      rd_chk(`OFF_CTRL, 32'h0, 32'h0, 1'b0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
  endtask

  task automatic push(input logic [15:0] v, input logic [2:0] tg);
    wr(`OFF_DESC_LO, {16'h0000, v});
    run(dstu_pkg::CMD_PUSH, tg);
  endtask

  // irq may be registered, so give it a cycle to settle
  task automatic irq_is(input logic x);
    repeat (2) @(negedge pclk);
    checks++;
    if (irq !== x) begin
      bad_count++;
      $display("[ERR] t=%0t irq %h exp %h", $time, irq, x);
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cycles = 0;
    bad_count = 0;
    checks = 0;
    void'($urandom(69));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset state and refused addresses
    rd_chk(`OFF_SP, 32'h00000100, m16, 1'b0);
    rd_chk(`OFF_STATUS, 32'h0, 32'h1F, 1'b0);
    rd_chk(`OFF_MASK, 32'h0, 32'h1F, 1'b0);
    rd_chk(12'h030, 32'h0, mall, 1'b1);
    rd_chk(12'h006, 32'h0, mall, 1'b1);
    // postfix: a b op over a filler that spills to memory; sp counts memory slots only
    for (int i = 0; i < 3; i++) begin
      a = $urandom & m16;
      b = $urandom & m16;
      r = (i == 0) ? a + b : (i == 1) ? a - b : a * b;
      push(16'h0007, `TAG_DATA);
      push(a[15:0], `TAG_DATA);
      rd_chk(`OFF_SP, 32'h00000100, m16, 1'b0);
      push(b[15:0], `TAG_DATA);
      rd_chk(`OFF_SP, 32'h00000101, m16, 1'b0);
      rd_chk(`OFF_TOS_A, b, m16, 1'b0);
      rd_chk(`OFF_TOS_B, a, m16, 1'b0);
      run(ops[i], `TAG_DATA);
      rd_chk(`OFF_TOS_A, r, mall, 1'b0);
      rd_chk(`OFF_TOS_B, 32'h00000007, m16, 1'b0);
      rd_chk(`OFF_SP, 32'h00000100, m16, 1'b0);
      run(dstu_pkg::CMD_POP, `TAG_DATA);
      rd_chk(`OFF_TOS_A, 32'h00000007, m16, 1'b0);
      run(dstu_pkg::CMD_POP, `TAG_DATA);
    end
    // popping the empty stack flags underflow
    run(dstu_pkg::CMD_POP, `TAG_DATA);
    rd_chk(`OFF_STATUS, s_un, s_un, 1'b0);
    // code word at 0x20+1*16+3 must survive a later store
    rd_chk(`OFF_STATUS, 32'h0, 32'h0, 1'b0);
    wr(`OFF_MASK, s_pr);
    wr(`OFF_DBASE, 32'h00000020);
    wr(`OFF_COUPLE, {16'h0000, 4'h1, 12'h003});
    push(16'hC0DE, `TAG_CODE);
    run(dstu_pkg::CMD_STORE, `TAG_DATA);
    rd_chk(`OFF_STATUS, 32'h0, s_pr, 1'b0);
    push(16'h5A5A, `TAG_DATA);
    run(dstu_pkg::CMD_STORE, `TAG_DATA);
    irq_is(1'b1);
    rd_chk(`OFF_STATUS, s_pr, s_pr, 1'b0);
    run(dstu_pkg::CMD_FETCH, `TAG_DATA);
    rd_chk(`OFF_TOS_A, 32'h0000C0DE, m16, 1'b0);
    // data word at 0x34 stays writable
    wr(`OFF_COUPLE, {16'h0000, 4'h1, 12'h004});
    push(16'h1111, `TAG_DATA);
    run(dstu_pkg::CMD_STORE, `TAG_DATA);
    push(16'h2222, `TAG_DATA);
    run(dstu_pkg::CMD_STORE, `TAG_DATA);
    rd_chk(`OFF_STATUS, 32'h0, s_pr, 1'b0);
    // same word through another base and level: 0x14 + 2*16 + 0
    wr(`OFF_DBASE, 32'h00000014);
    wr(`OFF_COUPLE, {16'h0000, 4'h2, 12'h000});
    run(dstu_pkg::CMD_FETCH, `TAG_DATA);
    rd_chk(`OFF_TOS_A, 32'h00002222, m16, 1'b0);
    rd_chk(`OFF_RESULT, 32'h00002222, mall, 1'b0);
    // absent segment: unmasked then masked, read clears
    wr(`OFF_MASK, s_ab);
    wr(`OFF_DESC_LO, 32'h00040040);
    wr(`OFF_DESC_HI, 32'h0);
    run(dstu_pkg::CMD_REF, `TAG_DATA);
    irq_is(1'b1);
    rd_chk(`OFF_STATUS, s_ab, s_ab, 1'b0);
    irq_is(1'b0);
    rd_chk(`OFF_STATUS, 32'h0, s_ab, 1'b0);
    wr(`OFF_MASK, 32'h0);
    run(dstu_pkg::CMD_REF, `TAG_DATA);
    irq_is(1'b0);
    rd_chk(`OFF_STATUS, s_ab, s_ab, 1'b0);
    wr(`OFF_DESC_HI, 32'h00000001);
    run(dstu_pkg::CMD_REF, `TAG_DATA);
    rd_chk(`OFF_STATUS, s_dn, s_ab | s_dn, 1'b0);
    // index reaches word count 2 on the second step only
    wr(`OFF_MASK, s_lm);
    wr(`OFF_DESC_LO, 32'h00020040);
    wr(`OFF_INDEX, 32'h0);
    run(dstu_pkg::CMD_STEP, `TAG_DATA);
    rd_chk(`OFF_INDEX, 32'h1, m16, 1'b0);
    rd_chk(`OFF_STATUS, 32'h0, s_lm, 1'b0);
    irq_is(1'b0);
    run(dstu_pkg::CMD_STEP, `TAG_DATA);
    irq_is(1'b1);
    rd_chk(`OFF_STATUS, s_lm, s_lm, 1'b0);
    // save then restore returns the same top of stack
    rd_chk(`OFF_SP, 32'h0, 32'h0, 1'b0);
    sp = rd & m16;
    a = $urandom & m16;
    b = $urandom & m16;
    push(a[15:0], `TAG_DATA);
    push(b[15:0], `TAG_DATA);
    run(dstu_pkg::CMD_SAVE, `TAG_DATA);
    run(dstu_pkg::CMD_RESTORE, `TAG_DATA);
    rd_chk(`OFF_SP, sp + 2, m16, 1'b0);
    rd_chk(`OFF_TOS_A, b, m16, 1'b0);
    rd_chk(`OFF_TOS_B, a, m16, 1'b0);
    wrap_up();
  end
endmodule
